// ==== pdac_pkg.sv ====
// Purpose: Shared constants and carriers for the parallel converter host port.
// Assumes: 25 MHz system clock, one clock domain.
// Notes: Phase lengths are minimum hold times expressed in clock cycles.
package pdac_pkg;
    localparam int WORD_W = 12;
    localparam int CLK_MHZ = 25;
    // Setup, strobe and release times in nanoseconds, kept conservative.
    localparam int T_SETUP_NS = 40;
    localparam int T_STROBE_NS = 80;
    localparam int T_RELEASE_NS = 40;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int RELEASE_CYC = (T_RELEASE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 4;
    localparam logic [11:0] WORD_RESET = 12'h000;

    typedef logic [WORD_W-1:0] word_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RELEASE
    } phase_e;

    typedef struct packed {
        logic sel_n;
        logic rd_wr;
        logic data_oe;
        word_t data_out;
    } pins_s;
endpackage

// ==== pdac_host.sv ====
// Purpose: Host controller driving the parallel port of a 12-bit converter.
// Assumes: Bus pins are synchronous to clock; the device answers within the strobe phase.
// Notes: One access at a time; req_ready is low while an access runs.
//
// What this block does
// [RULE_01] Each value moves as one whole 12-bit word on the data pins.
// [RULE_02] Select and read/write alone decide the direction of the shared bus.
// [RULE_03] A write holds read/write low while the word is driven, and select low only in the strobe phase.
// [RULE_04] The device loads its converter register on the select rising edge.
// [RULE_05] Every write gives select both a falling and a rising edge.
// [RULE_06] A readback holds read/write high, lowers select, never drives data.
// [RULE_07] The device drives the stored word onto the pins during readback.
// [RULE_08] The device leaves the bus idle while select is high or writing.
`timescale 1ns/1ns
module pdac_host (
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic req_valid, // Access request.
    output logic req_ready, // Host is idle and takes a request.
    input wire logic req_read, // One for readback, zero for write.
    input wire pdac_pkg::word_t req_data, // Word to write.
    output logic done, // One-cycle pulse at end of access.
    output pdac_pkg::word_t rd_data, // Last word read back.
    output logic sel_n, // Select pin, active low.
    output logic rd_wr, // Read/write pin, high for read.
    output pdac_pkg::word_t db_o, // Data pins, output value.
    output logic db_oe, // Data pins, high while host drives.
    input wire pdac_pkg::word_t db_i // Data pins, input value.
);
    pdac_pkg::phase_e phase;
    pdac_pkg::phase_e next_phase;
    pdac_pkg::pins_s pins;
    pdac_pkg::pins_s next_pins;
    logic [pdac_pkg::CNT_W-1:0] cnt;
    logic [pdac_pkg::CNT_W-1:0] next_cnt;
    logic is_read;
    logic done_q;

    // ****************************************************************
    // Phase sequencing
    // ****************************************************************
    function automatic logic [pdac_pkg::CNT_W-1:0] cyc(input int n);
        cyc = pdac_pkg::CNT_W'(n - 1);
    endfunction

    wire cnt_zero = (cnt == '0);
    wire take = req_valid && (phase == pdac_pkg::ST_IDLE);

    assign req_ready = (phase == pdac_pkg::ST_IDLE);

    always_comb begin
        next_phase = phase;
        next_cnt = cnt_zero ? cnt : cnt - 1'b1;
        next_pins = pins;
        unique case (phase)
            pdac_pkg::ST_IDLE: begin
                next_pins.sel_n = 1'b1;
                next_pins.data_oe = 1'b0;
                if (req_valid) begin
                    // Direction and data settle before select falls.
                    next_pins.rd_wr = req_read; // [RULE_02]
                    next_pins.data_oe = !req_read; // [RULE_03] [RULE_06]
                    next_pins.data_out = req_data; // [RULE_01]
                    next_cnt = cyc(pdac_pkg::SETUP_CYC);
                    next_phase = pdac_pkg::ST_SETUP;
                end
            end
            pdac_pkg::ST_SETUP: begin
                if (cnt_zero) begin
                    next_pins.sel_n = 1'b0; // [RULE_05]
                    next_cnt = cyc(pdac_pkg::STROBE_CYC);
                    next_phase = pdac_pkg::ST_STROBE;
                end
            end
            pdac_pkg::ST_STROBE: begin
                if (cnt_zero) begin
                    // Rising select loads the converter; data still held.
                    next_pins.sel_n = 1'b1; // [RULE_04] [RULE_05]
                    next_cnt = cyc(pdac_pkg::RELEASE_CYC);
                    next_phase = pdac_pkg::ST_RELEASE;
                end
            end
            pdac_pkg::ST_RELEASE: begin
                if (cnt_zero) begin
                    next_pins.data_oe = 1'b0;
                    next_pins.rd_wr = 1'b1;
                    next_phase = pdac_pkg::ST_IDLE;
                end
            end
            default: next_phase = pdac_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase <= pdac_pkg::ST_IDLE;
            cnt <= '0;
            pins <= '{sel_n: 1'b1, rd_wr: 1'b1, data_oe: 1'b0,
                      data_out: pdac_pkg::WORD_RESET};
        end else begin
            phase <= next_phase;
            cnt <= next_cnt;
            pins <= next_pins;
        end
    end

    // ****************************************************************
    // Readback capture and completion
    // ****************************************************************
    // Sampling on the last strobe cycle gives the device the longest drive time.
    wire sample = (phase == pdac_pkg::ST_STROBE) && cnt_zero && is_read;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            is_read <= 1'b0;
            rd_data <= pdac_pkg::WORD_RESET;
            done_q <= 1'b0;
        end else begin
            if (take) begin
                is_read <= req_read;
            end
            if (sample) begin
                rd_data <= db_i; // [RULE_07]
            end
            done_q <= (phase == pdac_pkg::ST_RELEASE) && cnt_zero;
        end
    end

    assign done = done_q;
    assign sel_n = pins.sel_n;
    assign rd_wr = pins.rd_wr;
    assign db_o = pins.data_out;
    assign db_oe = pins.data_oe;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Counts select-low cycles, so an over-long strobe is caught without a long repetition.
    logic [pdac_pkg::CNT_W-1:0] low_run;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            low_run <= '0;
        end else begin
            low_run <= sel_n ? '0 : low_run + 1'b1;
        end
    end

    // Two cycles is the strobe length; the counter check below bounds it from above.
    sequence s_sel_low_n;
        !sel_n [*2];
    endsequence

    property p_write_drive;
        @(posedge clock) disable iff (!nrst)
        (!sel_n && !rd_wr) |-> db_oe;
    endproperty
    a_write_drive: assert property (p_write_drive) else $error("write without bus drive"); // [RULE_03]

    property p_read_quiet;
        @(posedge clock) disable iff (!nrst)
        (rd_wr && !sel_n) |-> !db_oe;
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("host drove bus in readback"); // [RULE_06]

    property p_strobe_edges;
        @(posedge clock) disable iff (!nrst)
        $fell(sel_n) |-> s_sel_low_n ##1 sel_n;
    endproperty
    a_strobe_edges: assert property (p_strobe_edges) else $error("select pulse malformed"); // [RULE_05]

    property p_stable_word;
        @(posedge clock) disable iff (!nrst)
        !sel_n |-> ($stable(db_o) && $stable(rd_wr));
    endproperty
    a_stable_word: assert property (p_stable_word) else $error("bus changed under select"); // [RULE_01]

    property p_hold_after_rise;
        @(posedge clock) disable iff (!nrst)
        ($rose(sel_n) && !rd_wr) |-> db_oe && $stable(db_o);
    endproperty
    a_hold_after_rise: assert property (p_hold_after_rise) else $error("data released at edge"); // [RULE_04]

    property p_capture;
        @(posedge clock) disable iff (!nrst)
        ($rose(sel_n) && rd_wr) |-> (rd_data == $past(db_i));
    endproperty
    a_capture: assert property (p_capture) else $error("readback word not captured"); // [RULE_07]

    property p_dir_idle;
        @(posedge clock) disable iff (!nrst)
        req_ready |-> sel_n;
    endproperty
    a_dir_idle: assert property (p_dir_idle) else $error("select low while idle"); // [RULE_02]

    property p_done_after;
        @(posedge clock) disable iff (!nrst)
        (take) |-> ##[4:20] done;
    endproperty
    a_done_after: assert property (p_done_after) else $error("access did not finish"); // [RULE_05]

    property p_low_bound;
        @(posedge clock) disable iff (!nrst)
        (low_run <= pdac_pkg::STROBE_CYC);
    endproperty
    a_low_bound: assert property (p_low_bound) else $error("select held low too long"); // [RULE_05]

    // The word must already be on the pins when select falls for a write.
    property p_setup_first;
        @(posedge clock) disable iff (!nrst)
        ($fell(sel_n) && !rd_wr) |-> $past(db_oe);
    endproperty
    a_setup_first: assert property (p_setup_first) else $error("select fell before drive"); // [RULE_03]

    // Direction and drive turn together, so a read never overlaps host drive.
    property p_read_never_drives;
        @(posedge clock) disable iff (!nrst)
        rd_wr |-> !db_oe;
    endproperty
    a_read_never_drives: assert property (p_read_never_drives) else $error("drive while read"); // [RULE_06]

    property p_done_pulse;
        @(posedge clock) disable iff (!nrst)
        done |=> !done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle"); // [RULE_05]

    property p_bus_free_idle;
        @(posedge clock) disable iff (!nrst)
        done |-> (!db_oe && rd_wr && req_ready);
    endproperty
    a_bus_free_idle: assert property (p_bus_free_idle) else $error("bus not released at end"); // [RULE_02]
endmodule

// ==== pdac_dev.sv ====
// Purpose: Behavioural model of the converter's parallel port, seen from the bus.
// Assumes: No clock; reacts to select and read/write levels and edges.
// Notes: An undriven bus shows the inverse of its last driven value.
`timescale 1ns/1ns
module pdac_dev (
    input wire logic sel_n, // Select pin, active low.
    input wire logic rd_wr, // Read/write pin, high for read.
    input wire logic db_oe, // Host drives the data pins.
    input wire pdac_pkg::word_t db_o, // Host drive value.
    output pdac_pkg::word_t db_i, // Resolved data pins.
    output pdac_pkg::word_t dac // Converter register.
);
    pdac_pkg::word_t last;
    logic dev_oe;
    initial dac = pdac_pkg::WORD_RESET;
    // The device drives only while selected for a read.
    assign dev_oe = !sel_n && rd_wr;
    // Two drivers at once make the bus unknown, so any contention shows up.
    assign db_i = (dev_oe && db_oe) ? 'x : dev_oe ? dac : db_oe ? db_o : ~last;
    always @(dev_oe or db_oe or dac or db_o) begin
        if (dev_oe) begin
            last = dac;
        end else if (db_oe) begin
            last = db_o;
        end
    end
    always @(posedge sel_n) begin
        if (!rd_wr) begin
            dac <= db_i;
        end
    end
endmodule

// ==== testbench.sv ====
// Purpose: Self-checking bench for the converter host port.
// Assumes: Inputs change on the falling clock edge.
// Notes: The device model supplies the far side of the bus.
`timescale 1ns/1ns
module testbench;
    logic clock, nrst, req_valid, req_read, req_ready, done, sel_n, rd_wr, db_oe;
    pdac_pkg::word_t req_data, rd_data, db_o, db_i, dac;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    pdac_host dut_u (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
        .req_read(req_read), .req_data(req_data), .done(done), .rd_data(rd_data),
        .sel_n(sel_n), .rd_wr(rd_wr), .db_o(db_o), .db_oe(db_oe), .db_i(db_i));
    pdac_dev dev_u (.sel_n(sel_n), .rd_wr(rd_wr), .db_oe(db_oe), .db_o(db_o), .db_i(db_i),
        .dac(dac));
    initial begin
        clock = 0;
        forever #20 clock = ~clock;
    end
    task automatic cmp(input string what, input pdac_pkg::word_t exp, input pdac_pkg::word_t got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("mismatches %0d of %0d comparisons", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A poke raises a second request while busy; it must be ignored.
    // The request drops after the take edge, so a following call may raise it again at once.
    task automatic access(input logic rd, input pdac_pkg::word_t w, input logic poke);
        int n;
        int low;
        int busy;
        logic oe;
        logic clash;
        n = 0;
        low = 0;
        busy = 0;
        oe = 0;
        clash = 0;
        req_valid = 1;
        req_read = rd;
        req_data = w;
        @(negedge clock);
        while (done !== 1'b1 && n < 20) begin
            req_valid = poke && n == 2;
            req_data = ~w;
            low += (sel_n === 1'b0);
            busy += (req_ready === 1'b0);
            oe |= (db_oe === 1'b1);
            clash |= (sel_n === 1'b0) && $isunknown(db_i);
            n++;
            @(negedge clock);
        end
        cmp("done", 12'h001, {11'h000, done});
        cmp("ready at done", 12'h001, {11'h000, req_ready});
        cmp("select low cycles", 12'(pdac_pkg::STROBE_CYC), low[11:0]);
        cmp("busy cycles", 12'(pdac_pkg::SETUP_CYC + pdac_pkg::STROBE_CYC +
            pdac_pkg::RELEASE_CYC), busy[11:0]);
        cmp("host drive", {11'h000, !rd}, {11'h000, oe});
        cmp("bus clash", 12'h000, {11'h000, clash});
    endtask
    task automatic t_reset();
        cmp("idle select", 12'h001, {11'h000, sel_n});
        cmp("idle read/write", 12'h001, {11'h000, rd_wr});
        cmp("idle drive", 12'h000, {11'h000, db_oe});
        cmp("idle ready", 12'h001, {11'h000, req_ready});
        cmp("reset readback", 12'h000, rd_data);
        access(1, 12'h000, 0);
        cmp("first readback", 12'h000, rd_data);
    endtask
    task automatic t_write_read();
        access(0, 12'hA5C, 0);
        cmp("converter", 12'hA5C, dac);
        access(1, 12'h000, 0);
        cmp("readback", 12'hA5C, rd_data);
    endtask
    task automatic t_back_to_back();
        access(0, 12'hFFF, 0);
        cmp("converter", 12'hFFF, dac);
        access(0, 12'h000, 0);
        cmp("converter", 12'h000, dac);
        access(1, 12'h000, 0);
        cmp("readback", 12'h000, rd_data);
    endtask
    task automatic t_refuse();
        access(0, 12'h123, 1);
        cmp("converter", 12'h123, dac);
        @(negedge clock);
        cmp("done pulse", 12'h000, {11'h000, done});
        cmp("not queued", 12'h001, {11'h000, req_ready});
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        nrst = 0;
        req_valid = 0;
        req_read = 0;
        req_data = 12'h000;
        repeat (5) @(negedge clock);
        nrst = 1;
        @(negedge clock);
        t_reset();
        t_write_read();
        t_back_to_back();
        t_refuse();
        results();
    end
endmodule
